/* panel_control.sv */
// Front panel and rear input control of a presettable event counter
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Clear loads zero or setpoint by mode
// - Front clear works only when rear-enabled
// - Clear aborts editing, outputs off, display cleared
// - Setpoint plus clear edits timed duration
// - First setpoint key shows and edits setpoint
// - Second setpoint key only on dual build
// - Accept stores and applies edited value
// - Accept ends self-test
// - Scale key edits scale, dual build only
// - Slow setting debounces count, 5 ms phases
// - Fast setting bypasses count debounce
// - Bad stored data shows fault, keeps running
// - Accept removes the stored-data fault
// - Remote clear low holds cleared state
// - Edit lock high permits edits and tests
// - Edit lock low refuses edits and tests
// - Direction high counts up, low down
// - Remote clear acts within 10 ms
// - Scale edit needs scale switch up
// - Edit timeout keeps previous stored value
module panel_control #(
	parameter int unsigned HOLD_CYCLES  = panel_pkg::HOLD_CYC,
	parameter int unsigned PHASE_CYCLES = panel_pkg::SLOW_PHASE_CYC,
	parameter int unsigned DEB_CYCLES   = panel_pkg::KEY_DEB_CYC
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire panel_pkg::keys_type  keys,
	input  wire panel_pkg::rear_type  rear,
	input  wire logic                 count_input_n,
	input  wire logic                 output_active,
	output logic                      outputs_off,
	output logic                      display_fault,
	output logic [23:0]               count_value,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	import panel_pkg::*;

	localparam int unsigned NF = 11;       // Filtered input count
	localparam int unsigned HW = 32;       // Hold timer width

	logic [NF-1:0]  raw_in;                // Raw inputs into filters
	logic [NF-1:0]  lvl;                   // Debounced levels
	logic [NF-1:0]  rise;                  // Press edges
	logic           cnt_pulse;             // One count event
	mode_type       mode_q;                // Panel mode
	target_type     tgt_q;                 // Value under edit
	logic [HW-1:0]  hold_q;                // Edit timeout timer
	logic [23:0]    edit_q;                // Value being edited
	logic [23:0]    sp1_q;                 // Stored setpoint one
	logic [23:0]    sp2_q;                 // Stored setpoint two
	logic [23:0]    to1_q;                 // Stored timed duration one
	logic [23:0]    to2_q;                 // Stored timed duration two
	logic [23:0]    scale_q;               // Stored scale factor
	logic           rtp_q;                 // Clear to setpoint mode
	logic           dual_q;                // Dual setpoint build
	logic           bad_q;                 // Stored data check failed
	logic           aw_got_q;              // Write address held
	logic           w_got_q;               // Write data held
	logic [7:0]     awaddr_q;              // Captured write address
	logic [31:0]    wdata_q;               // Captured write data
	logic           do_clear;              // Any clear this cycle
	logic           front_clear;           // Accepted front clear
	logic           unlocked;              // Edit lock input high
	logic           hold_done;             // Timeout reached

	// Input ordering: keys, then rear controls
	assign raw_in = {keys.clear_key, keys.first_setpoint_key, keys.second_setpoint_key,
		keys.accept_key, keys.scale_factor_key, rear.front_clear_enable_switch,
		rear.input_speed_switch, rear.scale_edit_switch, rear.remote_clear_input,
		rear.edit_lock_input, rear.count_direction_input};

	// One filter per input; control lines idle high through pull-ups
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++)
		begin : g_flt
			input_filter #(
				.STABLE_CYC (DEB_CYCLES),
				.RESET_LVL  ((gi <= 2) ? 1'b1 : 1'b0)
			) u_flt (
				.aclk    (aclk),
				.aresetn (aresetn),
				.raw     (raw_in[gi]),
				.level   (lvl[gi]),
				.rise    (rise[gi])
			);
		end
	endgenerate

	// Count input conditioning
	count_filter #(
		.PHASE_CYC (PHASE_CYCLES)
	) u_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw_n   (count_input_n),
		.slow    (~lvl[4]),
		.pulse   (cnt_pulse)
	);

	// Decoded levels and press edges, bit order from raw_in
	logic k_clr_r, k_sp1, k_sp2, k_acc_r, k_sf_r;
	logic clr_en, sf_sw, rem_n, dir_up;
	assign k_clr_r  = rise[10];
	assign k_sp1    = lvl[9];
	assign k_sp2    = lvl[8];
	assign k_acc_r  = rise[7];
	assign k_sf_r   = rise[6];
	assign clr_en   = lvl[5];
	assign sf_sw    = lvl[3];
	assign rem_n    = lvl[2];
	assign unlocked = lvl[1];
	assign dir_up   = lvl[0];

	// Setpoint plus clear is a duration view, not a clear
	assign front_clear = k_clr_r & clr_en & ~k_sp1 & ~(k_sp2 & dual_q);
	// Remote filter holds 2 ms, well inside the 10 ms response
	assign do_clear  = front_clear | ~rem_n;
	assign hold_done = (hold_q == '0);

	// Bus strobes, each high for the one cycle in which a write lands
	logic ctrl_wr;
	logic test_req;
	logic edit_wr;
	assign ctrl_wr  = aw_got_q & w_got_q & ~s_axi_bvalid & (awaddr_q == REG_CTRL);
	assign test_req = ctrl_wr & wdata_q[CTRL_SELF_BIT];
	// Edit buffer from bus stands in for digit keys
	assign edit_wr  = aw_got_q & w_got_q & ~s_axi_bvalid & (awaddr_q == REG_EDIT);

	// Panel mode and edit target
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_q <= MODE_IDLE;
			tgt_q  <= TGT_SP1;
			hold_q <= '0;
			edit_q <= '0;
		end
		else if (do_clear)
		begin
			mode_q <= MODE_IDLE;
			hold_q <= '0;
		end
		else if (test_req)
			mode_q <= MODE_TEST;
		else if (mode_q == MODE_TEST)
		begin
			if (k_acc_r)
				mode_q <= MODE_IDLE;
		end
		else if (k_clr_r & clr_en & k_sp1)
		begin
			mode_q <= MODE_VIEW;
			tgt_q  <= TGT_TO1;
			edit_q <= to1_q;
			hold_q <= HW'(HOLD_CYCLES);
		end
		else if (k_clr_r & clr_en & k_sp2 & dual_q)
		begin
			mode_q <= MODE_VIEW;
			tgt_q  <= TGT_TO2;
			edit_q <= to2_q;
			hold_q <= HW'(HOLD_CYCLES);
		end
		else if (rise[9])
		begin
			mode_q <= MODE_VIEW;
			tgt_q  <= TGT_SP1;
			edit_q <= sp1_q;
			hold_q <= HW'(HOLD_CYCLES);
		end
		else if (rise[8] & dual_q)
		begin
			mode_q <= MODE_VIEW;
			tgt_q  <= TGT_SP2;
			edit_q <= sp2_q;
			hold_q <= HW'(HOLD_CYCLES);
		end
		else if (k_sf_r & dual_q)
		begin
			mode_q <= MODE_VIEW;
			tgt_q  <= TGT_SCALE;
			edit_q <= scale_q;
			hold_q <= HW'(HOLD_CYCLES);
		end
		else if (mode_q == MODE_VIEW)
		begin
			// Software digits replace the shown value
			if (edit_wr)
				edit_q <= wdata_q[VAL_W-1:0];
			// Timer restarts while either setpoint key is held
			if (k_sp1 | k_sp2)
				hold_q <= HW'(HOLD_CYCLES);
			else if (k_acc_r | hold_done)
				mode_q <= MODE_IDLE;
			else
				hold_q <= hold_q - HW'(1);
		end
	end

	// Write permission for the value under edit
	logic may_store;
	assign may_store = unlocked & ((tgt_q != TGT_SCALE) | sf_sw);

	// Stored values and control written by accept or bus
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sp1_q   <= SP1_RST;
			sp2_q   <= SP2_RST;
			to1_q   <= TO_RST;
			to2_q   <= TO_RST;
			scale_q <= SCALE_RST;
			rtp_q   <= 1'b0;
			dual_q  <= 1'b0;
		end
		else
		begin
			if (!do_clear && mode_q == MODE_VIEW && k_acc_r && may_store)
			begin
				unique case (tgt_q)
					TGT_SP1:   sp1_q   <= edit_q;
					TGT_SP2:   sp2_q   <= edit_q;
					TGT_TO1:   to1_q   <= edit_q;
					TGT_TO2:   to2_q   <= edit_q;
					TGT_SCALE: scale_q <= edit_q;
					default:   sp1_q   <= sp1_q;
				endcase
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid)
			begin
				if (awaddr_q == REG_CTRL)
				begin
					rtp_q  <= wdata_q[CTRL_RTP_BIT];
					dual_q <= wdata_q[CTRL_DUAL_BIT];
				end
			end
		end
	end

	// Count value, clear first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_value <= '0;
		else if (do_clear)
			count_value <= rtp_q ? sp1_q : '0;
		else if (cnt_pulse)
			count_value <= dir_up ? count_value + 24'h00_0001
				: count_value - 24'h00_0001;
	end

	// Outputs forced off while clearing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			outputs_off <= 1'b1;
		else
			outputs_off <= do_clear | ~output_active;
	end

	// Stored-data fault: the start-up check lives outside and reports over the bus
	// Accept clears it, but a report in the same cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			display_fault <= 1'b0;
			bad_q         <= 1'b0;
		end
		else
		begin
			if (ctrl_wr && wdata_q[CTRL_BADSUM_BIT])
				display_fault <= 1'b1;
			else if (k_acc_r)
				display_fault <= 1'b0;
			if (ctrl_wr)
				bad_q <= wdata_q[CTRL_BADSUM_BIT];
		end
	end

	// AXI write channel capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == REG_CTRL || awaddr_q == REG_EDIT)
					? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
			end
		end
	end

	// Output testing only inside self-test and only with the lock open
	logic test_on_q; // Output test allowed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			test_on_q <= 1'b0;
		else
			test_on_q <= unlocked & (test_req | (mode_q == MODE_TEST));
	end

	// AXI read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_CTRL:   s_axi_rdata <= {28'h000_0000, bad_q, 1'b0, dual_q, rtp_q};
					REG_STATUS: s_axi_rdata <= {26'h000_0000, test_on_q, display_fault,
						unlocked, mode_q, do_clear};
					REG_COUNT:  s_axi_rdata <= {8'h00, count_value};
					REG_EDIT:   s_axi_rdata <= {8'h00, edit_q};
					REG_SP1:    s_axi_rdata <= {8'h00, sp1_q};
					REG_SP2:    s_axi_rdata <= {8'h00, sp2_q};
					REG_TO1:    s_axi_rdata <= {8'h00, to1_q};
					REG_TO2:    s_axi_rdata <= {8'h00, to2_q};
					REG_SCALE:  s_axi_rdata <= {8'h00, scale_q};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* panel_pkg.sv */
// Shared constants and carrier types for the counter panel control
package panel_pkg;

	// Clock rate and derived timing
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned CLK_NS          = 25;
	localparam int unsigned HOLD_S          = 10;
	localparam int unsigned HOLD_CYC        = HOLD_S * CLK_HZ;
	localparam int unsigned SLOW_PHASE_MS   = 5;
	localparam int unsigned SLOW_PHASE_CYC  = (SLOW_PHASE_MS * (CLK_HZ / 1000));
	localparam int unsigned CLEAR_RESP_MS   = 10;
	localparam int unsigned CLEAR_RESP_CYC  = (CLEAR_RESP_MS * (CLK_HZ / 1000));
	localparam int unsigned KEY_DEB_MS      = 2;
	localparam int unsigned KEY_DEB_CYC     = (KEY_DEB_MS * (CLK_HZ / 1000));
	localparam int unsigned VAL_W           = 24;
	localparam int unsigned TIMER_W         = 32;

	// Register map
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_COUNT    = 8'h08;
	localparam logic [7:0] REG_EDIT     = 8'h0C;
	localparam logic [7:0] REG_SP1      = 8'h10;
	localparam logic [7:0] REG_SP2      = 8'h14;
	localparam logic [7:0] REG_TO1      = 8'h18;
	localparam logic [7:0] REG_TO2      = 8'h1C;
	localparam logic [7:0] REG_SCALE    = 8'h20;

	// Control fields
	localparam int unsigned CTRL_RTP_BIT    = 0;
	localparam int unsigned CTRL_DUAL_BIT   = 1;
	localparam int unsigned CTRL_SELF_BIT   = 2;
	localparam int unsigned CTRL_BADSUM_BIT = 3;

	// Reset values
	localparam logic [23:0] SP1_RST   = 24'h00_01F4;
	localparam logic [23:0] SP2_RST   = 24'h00_03E8;
	localparam logic [23:0] TO_RST    = 24'h00_000A;
	localparam logic [23:0] SCALE_RST = 24'h01_86A0;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// Edit targets
	typedef enum logic [2:0] {
		TGT_SP1   = 3'b000,
		TGT_SP2   = 3'b001,
		TGT_TO1   = 3'b011,
		TGT_TO2   = 3'b010,
		TGT_SCALE = 3'b110
	} target_type;

	// Panel mode, Gray coded along idle -> view -> idle
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_VIEW = 2'b01,
		MODE_TEST = 2'b11
	} mode_type;

	// Front keys, raw levels
	typedef struct packed {
		logic clear_key;
		logic first_setpoint_key;
		logic second_setpoint_key;
		logic accept_key;
		logic scale_factor_key;
	} keys_type;

	// Rear switches and control inputs, raw levels
	typedef struct packed {
		logic front_clear_enable_switch;
		logic input_speed_switch;
		logic scale_edit_switch;
		logic remote_clear_input;
		logic edit_lock_input;
		logic count_direction_input;
	} rear_type;

endpackage

/* input_filter.sv */
// Synchroniser and debouncer for one slow input, with press-edge pulse
`timescale 1ns/1ps
module input_filter #(
	parameter int unsigned STABLE_CYC = 80_000,
	parameter logic        RESET_LVL  = 1'b0
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw,
	output logic      level,
	output logic      rise
);
	import panel_pkg::*;

	localparam int unsigned CW = $clog2(STABLE_CYC + 1);

	logic          meta_q;  // First synchroniser stage
	logic          sync_q;  // Second synchroniser stage
	logic [CW-1:0] cnt_q;   // Stability counter

	// Two-stage synchroniser; only sync_q reads meta_q
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= RESET_LVL;
			sync_q <= RESET_LVL;
		end
		else
		begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	// Level accepted only after it stands still long enough
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= '0;
			level <= RESET_LVL;
			rise  <= 1'b0;
		end
		else
		begin
			rise <= 1'b0;
			if (sync_q == level)
				cnt_q <= '0;
			else if (cnt_q >= CW'(STABLE_CYC - 1))
			begin
				cnt_q <= '0;
				level <= sync_q;
				rise  <= sync_q; // One pulse per press edge
			end
			else
				cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule

/* count_filter.sv */
// Count input conditioning: slow debounce or fast bypass, fall-edge pulse
`timescale 1ns/1ps
module count_filter #(
	parameter int unsigned PHASE_CYC = 200_000
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw_n,
	input  wire logic slow,
	output logic      pulse
);
	import panel_pkg::*;

	localparam int unsigned CW = $clog2(PHASE_CYC + 1);

	logic          meta_q;  // First stage
	logic          sync_q;  // Second stage
	logic          fast_q;  // Last fast sample
	logic          slow_q;  // Debounced level
	logic [CW-1:0] cnt_q;   // Phase counter

	// Synchroniser
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= raw_n;
			sync_q <= meta_q;
		end
	end

	// Fast path keeps one sample; slow path demands each phase stand 5 ms
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fast_q <= 1'b1;
			slow_q <= 1'b1;
			cnt_q  <= '0;
			pulse  <= 1'b0;
		end
		else
		begin
			fast_q <= sync_q;
			pulse  <= 1'b0;
			if (!slow)
			begin
				pulse  <= fast_q & ~sync_q;
				slow_q <= sync_q;
				cnt_q  <= '0;
			end
			else if (sync_q == slow_q)
				cnt_q <= '0;
			else if (cnt_q >= CW'(PHASE_CYC - 1))
			begin
				cnt_q  <= '0;
				slow_q <= sync_q;
				pulse  <= ~sync_q;
			end
			else
				cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule

/* panel_control_asserts.sv */
// Port-level checks for the panel control block
`timescale 1ns/1ps
module panel_control_asserts (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire panel_pkg::rear_type rear,
	input wire logic                outputs_off,
	input wire logic [23:0]         count_value,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready
);
	import panel_pkg::*;
	// One clock domain, reset silences everything
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Ready only answers a pending request
	property p_aw_take; s_axi_awready |-> s_axi_awvalid; endproperty
	a_aw_take: assert property (p_aw_take) else $error("awready without awvalid");
	property p_w_take; s_axi_wready |-> s_axi_wvalid; endproperty
	a_w_take: assert property (p_w_take) else $error("wready without wvalid");
	// Read address accepted promptly, data one cycle later
	property p_ar_resp; $rose(s_axi_arvalid) |-> ##[1:4] s_axi_arready; endproperty
	a_ar_resp: assert property (p_ar_resp) else $error("arready late");
	property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_after: assert property (p_r_after) else $error("rvalid missing");
	// Write answer arrives promptly; answers stand unchanged until taken
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_b_after; $rose(s_axi_awvalid) |-> ##[1:6] s_axi_bvalid; endproperty
	a_b_after: assert property (p_b_after) else $error("bvalid late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	// Held remote clear forces outputs off within the response bound
	property p_rc_off;
		!rear.remote_clear_input [*8] |-> ##[0:8] outputs_off;
	endproperty
	a_rc_off: assert property (p_rc_off) else $error("remote clear ignored");
	// Count frozen while remote clear stays low
	property p_rc_hold;
		!rear.remote_clear_input [*8] ##1 !rear.remote_clear_input [*8]
			|-> $stable(count_value);
	endproperty
	a_rc_hold: assert property (p_rc_hold) else $error("count moved in clear");
endmodule

/* panel_operator.sv */
// Operator, rear switches and count sensor in front of the panel control
`timescale 1ns/1ps
module panel_operator #(
	parameter int unsigned SETTLE = 12
) (
	input wire logic            aclk,
	output panel_pkg::keys_type keys,
	output panel_pkg::rear_type rear,
	output logic                count_input_n
);
	import panel_pkg::*;
	// Idle panel: no key, rear lines open (pulled high)
	initial
	begin
		keys = 5'h00;
		rear = 6'h3F;
		count_input_n = 1'b1;
	end
	// Plain wait in clock cycles
	task waitc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Key levels held well past the debounce time
	task down(input keys_type k);
		@(posedge aclk);
		keys <= keys | k;
		waitc(SETTLE);
	endtask
	task up(input keys_type k);
		@(posedge aclk);
		keys <= keys & ~k;
		waitc(SETTLE);
	endtask
	// Rear switch change, then settle
	task set_rear(input rear_type r);
		@(posedge aclk);
		rear <= r;
		waitc(SETTLE);
	endtask
	// One count: low phase, then a longer high phase for sync latency
	task pulse(input int ph);
		@(posedge aclk);
		count_input_n <= 1'b0;
		waitc(ph);
		count_input_n <= 1'b1;
		waitc(ph + 10);
	endtask
endmodule

/* test_panel_control.sv */
// Directed test of the panel control via keys, rear lines and register bus
`timescale 1ns/1ps
module test_panel_control;
	import panel_pkg::*;
	localparam int unsigned HOLD = 200;    // Shortened view hold time
	localparam keys_type    K_CLR = 5'h10;
	localparam keys_type    K_SP1 = 5'h08;
	localparam keys_type    K_SP2 = 5'h04;
	localparam keys_type    K_ACC = 5'h02;
	localparam keys_type    K_SCL = 5'h01;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        output_active = 1'b1;   // Core asks for outputs on
	keys_type    keys;
	rear_type    rear;
	logic        count_input_n;
	logic        outputs_off;
	logic        display_fault;
	logic [23:0] count_value;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          err_total = 0;
	int          n_checks = 0;

	// Clock at 25 ns
	always #12.5 aclk = ~aclk;

	panel_operator panel_operator_i (.aclk(aclk), .keys(keys), .rear(rear),
		.count_input_n(count_input_n));
	panel_control #(.HOLD_CYCLES(HOLD), .PHASE_CYCLES(8), .DEB_CYCLES(4)) panel_control_i (
		.aclk(aclk), .aresetn(aresetn), .keys(keys), .rear(rear),
		.count_input_n(count_input_n), .output_active(output_active),
		.outputs_off(outputs_off), .display_fault(display_fault), .count_value(count_value),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	// Verdict and end of run
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Compare one value
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus write; bready stands from the start, answer taken at the bvalid edge
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) begin err_total++; conclude(); end
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask
	// Bus read with expected data and response
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) begin err_total++; conclude(); end
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	// Operator shortcuts
	task press(input keys_type k);
		panel_operator_i.down(k);
		panel_operator_i.up(k);
	endtask
	task pulse(input int ph); panel_operator_i.pulse(ph); endtask
	task rear_to(input rear_type r); panel_operator_i.set_rear(r); endtask
	// Open a value, load the edit buffer, accept
	task edit(input keys_type k, input logic [31:0] v);
		press(k);
		wr(REG_EDIT, v, RESP_OKAY);
		press(K_ACC);
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		panel_operator_i.waitc(20);
		chk(display_fault, 1'b0);
		rd(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		rd(REG_SP1, SP1_RST, RESP_OKAY);
		rd(REG_SP2, SP2_RST, RESP_OKAY);
		rd(REG_TO1, TO_RST, RESP_OKAY);
		rd(REG_SCALE, SCALE_RST, RESP_OKAY);
		rd(8'h40, 32'h0000_0000, RESP_SLVERR);
		wr(REG_COUNT, 32'h0000_0055, RESP_SLVERR);
		// Fast input, both directions
		repeat (3) pulse(3);
		chk(count_value, 32'h0000_0003);
		rear_to(6'h3E);
		pulse(3);
		chk(count_value, 32'h0000_0002);
		// Slow input: short phases are rejected
		rear_to(6'h2F);
		pulse(3);
		chk(count_value, 32'h0000_0002);
		pulse(12);
		chk(count_value, 32'h0000_0003);
		// Front clear gated by the rear switch
		rear_to(6'h1F);
		press(K_CLR);
		chk(count_value, 32'h0000_0003);
		rear_to(6'h3F);
		press(K_CLR);
		chk(count_value, 32'h0000_0000);
		// Clear to setpoint
		wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
		pulse(3);
		press(K_CLR);
		chk(count_value, SP1_RST);
		wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		// Setpoint view and store
		press(K_SP1);
		rd(REG_STATUS, 32'h0000_000A, RESP_OKAY);
		wr(REG_EDIT, 32'h0000_0123, RESP_OKAY);
		press(K_ACC);
		rd(REG_SP1, 32'h0000_0123, RESP_OKAY);
		// Second key absent on single build, present on dual
		press(K_SP2);
		rd(REG_STATUS, 32'h0000_0008, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
		edit(K_SP2, 32'h0000_0456);
		rd(REG_SP2, 32'h0000_0456, RESP_OKAY);
		// Setpoint held while clear pressed edits the timed duration
		panel_operator_i.down(K_SP1);
		press(K_CLR);
		panel_operator_i.up(K_SP1);
		wr(REG_EDIT, 32'h0000_0077, RESP_OKAY);
		press(K_ACC);
		rd(REG_TO1, 32'h0000_0077, RESP_OKAY);
		// Scale edit needs its rear switch up
		rear_to(6'h37);
		edit(K_SCL, 32'h0000_0099);
		rd(REG_SCALE, SCALE_RST, RESP_OKAY);
		rear_to(6'h3F);
		edit(K_SCL, 32'h0000_0099);
		rd(REG_SCALE, 32'h0000_0099, RESP_OKAY);
		// Edit lock refuses a store
		rear_to(6'h3D);
		edit(K_SP1, 32'h0000_0005);
		rd(REG_SP1, 32'h0000_0123, RESP_OKAY);
		rear_to(6'h3F);
		// View times out, previous value kept
		press(K_SP1);
		wr(REG_EDIT, 32'h0000_0006, RESP_OKAY);
		panel_operator_i.waitc(HOLD + 30);
		rd(REG_STATUS, 32'h0000_0008, RESP_OKAY);
		press(K_ACC);
		rd(REG_SP1, 32'h0000_0123, RESP_OKAY);
		// Clear aborts a view in progress
		press(K_SP1);
		press(K_CLR);
		rd(REG_STATUS, 32'h0000_0008, RESP_OKAY);
		// Self-test left with accept
		wr(REG_CTRL, 32'h0000_0006, RESP_OKAY);
		rd(REG_STATUS, 32'h0000_002E, RESP_OKAY);
		press(K_ACC);
		rd(REG_STATUS, 32'h0000_0008, RESP_OKAY);
		// Bad stored data raises the fault, accept removes it
		wr(REG_CTRL, 32'h0000_000A, RESP_OKAY);
		chk(display_fault, 1'b1);
		press(K_ACC);
		chk(display_fault, 1'b0);
		// Remote clear held low
		pulse(3);
		rear_to(6'h3B);
		panel_operator_i.waitc(8);
		chk(outputs_off, 1'b1);
		pulse(3);
		chk(count_value, 32'h0000_0000);
		rear_to(6'h3F);
		conclude();
	end
endmodule

bind panel_control panel_control_asserts chk_i (.aclk(aclk), .aresetn(aresetn),
	.rear(rear), .outputs_off(outputs_off), .count_value(count_value),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
